/* design/otc_top.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module otc_top
  import otc_pkg::*;
#(
  parameter int ADC_WIDTH = 12
)
(
  input  wire logic                 REF_CLK,
  input  wire logic                 RST,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [31:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 TEMP_SENSE_VALID,
  input  wire logic [ADC_WIDTH-1:0] TEMP_SENSE_DATA,
  output logic                      OVERTEMP_FLAG,
  output logic                      THRESHOLD_OUT_OF_RANGE
);

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic index_hit(input logic [31:0] addr,
                                     input logic [7:0]  idx);
    logic aligned;
    aligned = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h0);
    return aligned && (addr[9:2] == idx);
  endfunction : index_hit

  // ************************************************************
  // request decode
  // ************************************************************
  otc_req_type    req;
  otc_sample_type sample;
  logic           access;
  logic           hit_reading;
  logic           hit_threshold;
  logic           hit_status;
  logic           mapped;

  always_comb
  begin
    req.write     = PWRITE;
    req.index     = PADDR[9:2];
    req.wdata     = PWDATA;
    hit_reading   = index_hit(PADDR, OTC_IDX_READING);
    hit_threshold = index_hit(PADDR, OTC_IDX_THRESHOLD);
    hit_status    = index_hit(PADDR, OTC_IDX_STATUS);
    mapped        = hit_reading || hit_threshold || hit_status;
    access        = PSEL && PENABLE;
    sample.valid  = TEMP_SENSE_VALID;
    sample.code   = 16'(TEMP_SENSE_DATA);
  end

  // ************************************************************
  // bus answer: one wait state, then pready
  // ************************************************************
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        complete;
  logic        threshold_write;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]           threshold;
  logic [7:0]           next_threshold;
  logic [ADC_WIDTH-1:0] reading;
  logic [ADC_WIDTH-1:0] next_reading;
  logic                 have_reading;
  logic                 next_have_reading;
  logic                 out_of_range;
  logic                 next_out_of_range;
  logic [31:0]          status_word;
  logic [31:0]          reading_word;
  logic [31:0]          threshold_word;

  always_comb
  begin
    complete        = access && PREADY;
    threshold_write = complete && req.write && hit_threshold;
  end

  always_comb
  begin
    status_word = 32'h0;
    status_word[OTC_STAT_FLAG]  = OVERTEMP_FLAG;
    status_word[OTC_STAT_RANGE] = out_of_range;
    status_word[OTC_STAT_HAVE]  = have_reading;
    reading_word   = 32'(reading);
    threshold_word = {24'h0, threshold};
  end

  always_comb
  begin
    next_pready  = access && !PREADY;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0;
    if (access && !PREADY)
    begin
      next_pslverr = !mapped;
      if (!req.write && mapped)
      begin
        unique case (req.index)
          OTC_IDX_READING:   next_prdata = reading_word;
          OTC_IDX_THRESHOLD: next_prdata = threshold_word;
          OTC_IDX_STATUS:    next_prdata = status_word;
          default:           next_prdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end
    else
    begin
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA  <= next_prdata;
    end
  end

  // ************************************************************
  // threshold register
  // ************************************************************
  always_comb
  begin
    next_threshold = threshold;
    if (threshold_write)
      next_threshold = req.wdata[7:0];
    next_out_of_range = (next_threshold < OTC_CODE_MIN) ||
                        (next_threshold > OTC_CODE_MAX);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      threshold    <= OTC_THRESHOLD_RST;
      out_of_range <= 1'b0;
    end
    else
    begin
      threshold    <= next_threshold;
      out_of_range <= next_out_of_range;
    end
  end

  // ************************************************************
  // sense capture
  // ************************************************************
  always_comb
  begin
    next_reading      = reading;
    next_have_reading = have_reading;
    if (sample.valid)
    begin
      next_reading      = sample.code[ADC_WIDTH-1:0];
      next_have_reading = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      reading      <= '0;
      have_reading <= 1'b0;
    end
    else
    begin
      reading      <= next_reading;
      have_reading <= next_have_reading;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb
  begin
    THRESHOLD_OUT_OF_RANGE = out_of_range;
  end

  // ************************************************************
  // scaling and comparison
  // ************************************************************
  logic [31:0] reading_uv;
  logic [31:0] threshold_uv;

  always_comb
  begin
    reading_uv   = otc_reading_to_uv(16'(reading), ADC_WIDTH);
    threshold_uv = otc_code_to_uv(threshold);
  end

  otc_hyst u_hyst
  (
    .clk          (REF_CLK),
    .rst          (RST),
    .enable       (have_reading),
    .reading_uv   (reading_uv),
    .threshold_uv (threshold_uv),
    .flag         (OVERTEMP_FLAG)
  );

endmodule : otc_top

/* design/otc_pkg.sv */
// Summary of operation
// - compare programmed 8-bit threshold against latest temperature reading register
// - raise over-temperature flag when reading is below threshold
// - each threshold code step weighs 3.04 mV of sense voltage
// - flag carries 16 mV hysteresis above the threshold
// - reading full scale spans 0 V to 1.55 V for alignment
package otc_pkg;

  // ************************************************************
  // register map (printed offsets are indexes, byte = 4 * index)
  // ************************************************************
  localparam logic [7:0]  OTC_IDX_READING   = 8'h1a;
  localparam logic [7:0]  OTC_IDX_THRESHOLD = 8'h2f;
  localparam logic [7:0]  OTC_IDX_STATUS    = 8'h30;
  localparam logic [7:0]  OTC_THRESHOLD_RST = 8'h03;
  localparam logic [7:0]  OTC_CODE_MIN      = 8'h03;
  localparam logic [7:0]  OTC_CODE_MAX      = 8'hfa;
  localparam int          OTC_STAT_FLAG     = 0;
  localparam int          OTC_STAT_RANGE    = 1;
  localparam int          OTC_STAT_HAVE     = 2;

  // ************************************************************
  // scaling in microvolts
  // ************************************************************
  localparam logic [31:0] OTC_STEP_UV       = 32'h00000be0;
  localparam logic [31:0] OTC_FULL_SCALE_UV = 32'h0017a6b0;
  localparam logic [31:0] OTC_HYST_UV       = 32'h00003e80;
  localparam int          OTC_MAX_ADC_W     = 16;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        write;
    logic [7:0]  index;
    logic [31:0] wdata;
  } otc_req_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } otc_sample_type;

  // ************************************************************
  // conversions
  // ************************************************************
  function automatic logic [31:0] otc_reading_to_uv(input logic [15:0] code,
                                                    input int         width);
    logic [63:0] prod;
    prod = {48'h0, code} * {32'h0, OTC_FULL_SCALE_UV};
    return prod[width +: 32];
  endfunction : otc_reading_to_uv

  function automatic logic [31:0] otc_code_to_uv(input logic [7:0] code);
    logic [39:0] prod;
    prod = {32'h0, code} * {8'h0, OTC_STEP_UV};
    return prod[31:0];
  endfunction : otc_code_to_uv

endpackage : otc_pkg

/* design/otc_hyst.sv */
`timescale 1ns/1ps
module otc_hyst
  import otc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic [31:0] reading_uv,
  input  wire logic [31:0] threshold_uv,
  output logic             flag
);

  // ************************************************************
  // hysteresis comparator
  // ************************************************************
  logic        next_flag;
  logic [31:0] release_uv;

  always_comb
  begin
    release_uv = threshold_uv + OTC_HYST_UV;
    next_flag  = flag;
    if (enable)
    begin
      if (!flag && (reading_uv < threshold_uv))
        next_flag = 1'b1;
      else if (flag && (reading_uv > release_uv))
        next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end

endmodule : otc_hyst

/* test/otc_assertions.sv */
`timescale 1ns/1ps
module otc_assertions
  import otc_pkg::*;
#(parameter int ADC_WIDTH = 12)
(
  input wire logic                 REF_CLK,
  input wire logic                 RST,
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [31:0]          PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic [31:0]          PRDATA,
  input wire logic                 PREADY,
  input wire logic                 PSLVERR,
  input wire logic                 TEMP_SENSE_VALID,
  input wire logic [ADC_WIDTH-1:0] TEMP_SENSE_DATA,
  input wire logic                 OVERTEMP_FLAG,
  input wire logic                 THRESHOLD_OUT_OF_RANGE
);
  // ****
  // shadow state
  // ****
  logic [7:0]  thr, next_thr;
  logic [15:0] rd, next_rd;
  logic        hv, next_hv;
  logic [63:0] rd_uv, th_uv;
  always_comb
  begin
    next_thr = thr;
    next_rd  = rd;
    next_hv  = hv;
    if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 32'hbc) next_thr = PWDATA[7:0];
    if (TEMP_SENSE_VALID) next_rd = 16'(TEMP_SENSE_DATA);
    if (TEMP_SENSE_VALID) next_hv = 1'b1;
    if (RST) next_thr = 8'h03;
    if (RST) next_hv = 1'b0;
    if (RST) next_rd = '0;
    rd_uv = (64'(rd) * 64'(OTC_FULL_SCALE_UV)) >> ADC_WIDTH;
    th_uv = 64'(thr) * 64'(OTC_STEP_UV);
  end
  always_ff @(posedge REF_CLK)
  begin
    thr <= next_thr;
    rd  <= next_rd;
    hv  <= next_hv;
  end
  // ****
  // checks
  // ****
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence rd_done;
    PSEL && PENABLE && PREADY && !PWRITE;
  endsequence
  sequence acc_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  reading_read_a: assert property (rd_done ##0 PADDR == 32'h68
    |-> PRDATA == 32'($past(rd)))
    else $error("reading readback wrong");
  thr_read_a: assert property (rd_done ##0 PADDR == 32'hbc
    |-> PRDATA == 32'($past(thr)))
    else $error("threshold readback wrong");
  no_reading_a: assert property (!hv |=> !OVERTEMP_FLAG)
    else $error("flag without reading");
  set_below_a: assert property (hv && rd_uv < th_uv |=> OVERTEMP_FLAG)
    else $error("flag not set");
  hold_band_a: assert property (hv && rd_uv >= th_uv && rd_uv <= th_uv + OTC_HYST_UV
    |=> $stable(OVERTEMP_FLAG))
    else $error("flag moved in band");
  clear_above_a: assert property (hv && rd_uv > th_uv + OTC_HYST_UV |=> !OVERTEMP_FLAG)
    else $error("flag not cleared");
  ready_wait_a: assert property (acc_wait |=> PREADY)
    else $error("no ready after one wait");
  ready_once_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  range_flag_a: assert property (THRESHOLD_OUT_OF_RANGE ==
    (thr < OTC_CODE_MIN || thr > OTC_CODE_MAX))
    else $error("range flag wrong");
endmodule : otc_assertions
bind otc_top otc_assertions #(.ADC_WIDTH(ADC_WIDTH)) u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TEMP_SENSE_VALID(TEMP_SENSE_VALID),
  .TEMP_SENSE_DATA(TEMP_SENSE_DATA), .OVERTEMP_FLAG(OVERTEMP_FLAG),
  .THRESHOLD_OUT_OF_RANGE(THRESHOLD_OUT_OF_RANGE));

/* test/otc_tb.sv */
`timescale 1ns/1ps
module otc_tb;
  import otc_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, tv = 0, e, prdy, perr, flg, oor;
  logic [31:0] pa = 0, pwd = 0, prd, q;
  logic [11:0] td = 0;
  int          err_count = 0, checked = 0, seed = 48, thr = 3, rd, fm = 0, hv = 0, ob = 0, i;
  int          cd [4] = '{8'h03, 8'hfa, 8'h02, 8'hfb};
  always #12.5 clk = ~clk;
  otc_top DUT (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .TEMP_SENSE_VALID(tv), .TEMP_SENSE_DATA(td), .OVERTEMP_FLAG(flg),
    .THRESHOLD_OUT_OF_RANGE(oor));
  task results;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  task chk(input string n, input logic [31:0] s, x);
    checked++;
    if (s !== x)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, dt);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= dt;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 9);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (prdy !== 1'b1)
    begin
      err_count++;
      results;
    end
    @(posedge clk);
  endtask : apb
  task ev;
    longint u, t;
    u = (longint'(rd) * OTC_FULL_SCALE_UV) >> 12;
    t = thr * OTC_STEP_UV;
    if (hv && u < t) fm = 1;
    else if (hv && u > t + OTC_HYST_UV) fm = 0;
  endtask : ev
  task sense(input int v);
    tv <= 1'b1;
    td <= v[11:0];
    @(posedge clk);
    tv <= 1'b0;
    td <= ~v[11:0];
    rd = v & 4095;
    hv = 1;
    ev;
    repeat (2) @(posedge clk);
    chk("flag", flg, fm);
  endtask : sense
  task wthr(input int c);
    apb(1, 32'hbc, c + 32'h0000ab00);
    thr = c & 255;
    ob = thr < 3 || thr > 250;
    ev;
    @(posedge clk);
    chk("flag", flg, fm);
    apb(0, 32'hbc, 0);
    chk("thr", q, thr);
  endtask : wthr
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wthr(3);
    apb(0, 32'h100, 0);
    chk("err", {q[30:0], e}, 1);
    apb(1, 32'h69, 5);
    chk("err", e, 1);
    for (i = 0; i < 300; i++)
    begin
      if (i % 8 == 0) wthr(i < 32 ? cd[i / 8] : $random(seed));
      sense(thr * 8 + $random(seed) % 64);
      apb(0, 32'h68, 0);
      chk("read", q, rd);
      chk("err", e, 0);
      apb(0, 32'hc0, 0);
      chk("stat", q, hv * 4 + ob * 2 + fm);
      chk("oor", oor, ob);
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    thr = 3;
    rd = 0;
    hv = 0;
    fm = 0;
    ob = 0;
    @(posedge clk);
    chk("flag", flg, fm);
    chk("oor", oor, ob);
    apb(0, 32'hc0, 0);
    chk("stat", q, 0);
    apb(0, 32'hbc, 0);
    chk("thr", q, 3);
    apb(0, 32'h68, 0);
    chk("read", q, 0);
    sense(thr * 8 - 20);
    results;
  end
endmodule : otc_tb
